// File: hdl/mbo_unit.sv
// Memory block operation unit: reversed copy, block XOR and word increment.
// Summary of operation
// RQ1: The priority bit of a command selects low (0) or high (1) execution.
// RQ2: A finished command pulses the done event of its own priority level.
// RQ3: A command at a level already busy raises misuse and is not started.
// RQ4: Reversed copy takes an 8-bit count, 12-bit source and destination.
// RQ5: Reversed copy writes source byte n to destination start+count-1-n.
// RQ6: Block XOR writes source xor destination bytes over the destination.
// RQ7: Increment adds one to a little-endian word of 2^size bytes.
// RQ8: An increment size code of 3 raises the misuse fault.
// RQ9: Increment starting above 0x3fc raises the address range fault.
// RQ10: Copy or XOR touching bytes outside memory aborts with range fault.
module mbo_unit
  import mbo_pkg::*;
(
  input  wire logic     core_clk, // System clock, 50 MHz.
  input  wire logic     rst_b,    // Asynchronous reset, active low.
  input  wire mbo_cmd_t cmd,      // Command strobe with operands.
  output mbo_evt_t      evt,      // Event pulses and status.
  output logic          busy_lo,  // Low priority level busy.
  output logic          busy_hi   // High priority level busy.
);
  // One engine serves both levels; a pending low command waits while a high
  // one runs, which keeps the datapath small at the cost of latency.
  // Timing: a command is taken on the edge where its valid bit is high, the
  // busy flag of its level rises on that same edge and the engine leaves IDLE
  // one cycle later. Each byte costs one READ and one WRITE cycle, so a
  // block of C bytes ends about 2C+3 cycles after it was taken. The done and
  // fault events are single-cycle pulses; the busy flag falls together with
  // the done pulse, so the host may issue the next command on that level
  // right after it sees done.
  typedef struct packed {
    mbo_state_t  st;
    logic [1:0]  pend;
    mbo_cmd_t    [1:0] slot;
    logic        cur;
    logic [7:0]  idx;
    logic [7:0]  rd_byte;
    logic        carry;
    logic        range_err;
    mbo_evt_t    evt;
  } mbo_reg_t;

  // Engine state and the byte store.
  mbo_reg_t   q_r;
  mbo_reg_t   q_nxt;
  logic [7:0] mem_r [MEM_BYTES];
  logic       mem_we;
  logic [9:0] mem_wa;
  logic [7:0] mem_wd;

  mbo_cmd_t    act;
  logic [12:0] s_end;
  logic [12:0] d_end;
  logic [11:0] ra;
  logic [11:0] wa;
  logic [8:0]  sum;
  logic [7:0]  nbytes;
  logic        inc_size_bad;
  logic        inc_range_bad;
  logic        blk_range_bad;
  logic        inc_last;
  logic        blk_last;

  // Operand checks and address arithmetic for the active slot. They only
  // look at the latched command, so a new command arriving on the same
  // edge cannot disturb a job that is already running.
  always_comb begin
    act    = q_r.slot[q_r.cur];
    s_end  = {1'b0, act.src} + {5'h00, act.count} - 13'h0001;
    d_end  = {1'b0, act.dst} + {5'h00, act.count} - 13'h0001;
    nbytes = 8'h01 << act.count[1:0];
    ra     = act.src + {4'h0, q_r.idx};
    unique case (act.op)
      MBO_COPYR: begin
        wa = act.dst + {4'h0, act.count} - 12'h001 - {4'h0, q_r.idx}; // RQ5
      end
      MBO_XOR: begin
        wa = act.dst + {4'h0, q_r.idx}; // RQ6
      end
      default: begin
        wa = ra; // RQ7
      end
    endcase
    sum           = {1'b0, q_r.rd_byte} + {8'h00, q_r.carry};
    inc_size_bad  = act.count[1:0] == INC_SIZE_BAD; // RQ8
    // Four bytes are always reachable, even for a one-byte increment.
    inc_range_bad = act.src > INC_LAST_ADDR; // RQ9
    // An empty block touches nothing, so it can never be out of range.
    blk_range_bad = act.count != 8'h00 &&
                    (s_end > {1'b0, MEM_LAST} ||
                     d_end > {1'b0, MEM_LAST}); // RQ10
    inc_last      = q_r.idx == nbytes;
    blk_last      = q_r.idx == act.count;
  end

  // Next state of the engine and of the two command slots.
  always_comb begin
    q_nxt  = q_r;
    q_nxt.evt = '0;
    mem_we = 1'b0;
    mem_wa = wa[9:0];
    mem_wd = 8'h00;
    // A refused command leaves the running job and its slot untouched.
    if (cmd.valid) begin
      if (q_r.pend[cmd.prio]) begin
        q_nxt.evt.misuse_fault = 1'b1; // RQ3
      end else begin
        q_nxt.slot[cmd.prio] = cmd; // RQ1 RQ4
        q_nxt.pend[cmd.prio] = 1'b1;
      end
    end

    // A job walks IDLE, then READ and WRITE once per byte, then DONE. Every
    // check sits in READ so that an illegal job ends before any write.
    unique case (q_r.st)
      ST_IDLE: begin
        // High goes first when both levels wait; a low job never preempts.
        if (q_r.pend != 2'b00) begin
          q_nxt.cur   = q_r.pend[1]; // RQ1
          q_nxt.idx   = 8'h00;
          // The carry starts at one, which is the increment itself.
          q_nxt.carry = 1'b1;
          q_nxt.range_err = 1'b0;
          q_nxt.st    = ST_READ;
        end
      end

      ST_READ: begin
        // Range checks repeat on every READ pass; they are constant per job.
        if (act.op == MBO_INC) begin
          if (inc_size_bad) begin
            q_nxt.evt.misuse_fault = 1'b1; // RQ8
            q_nxt.st = ST_DONE;
          end else if (inc_range_bad) begin
            q_nxt.range_err = 1'b1; // RQ9
            q_nxt.st = ST_DONE;
          end else if (inc_last) begin
            q_nxt.st = ST_DONE;
          end else begin
            q_nxt.rd_byte = mem_r[ra[9:0]];
            q_nxt.st = ST_WRITE;
          end
        end else if (blk_range_bad) begin
          q_nxt.range_err = 1'b1; // RQ10
          q_nxt.st = ST_DONE;
        end else if (blk_last) begin
          q_nxt.st = ST_DONE;
        end else begin
          q_nxt.rd_byte = mem_r[ra[9:0]];
          q_nxt.st = ST_WRITE;
        end
      end

      ST_WRITE: begin
        mem_we = 1'b1;
        // XOR reads the destination byte in the same cycle it overwrites it.
        unique case (act.op)
          MBO_XOR: begin
            mem_wd = q_r.rd_byte ^ mem_r[wa[9:0]]; // RQ6
          end
          MBO_INC: begin
            mem_wd      = sum[7:0]; // RQ7
            q_nxt.carry = sum[8];
          end
          MBO_COPYR: begin
            mem_wd = q_r.rd_byte; // RQ5
          end
          default: begin
            mem_wd = 8'h00;
          end
        endcase
        q_nxt.idx = q_r.idx + 8'h01;
        q_nxt.st  = ST_READ;
      end

      ST_DONE: begin
        // Done is raised whatever the outcome of the job.
        q_nxt.evt.low_priority_done  = ~q_r.cur; // RQ2
        q_nxt.evt.high_priority_done = q_r.cur; // RQ2
        q_nxt.evt.address_range_fault = q_r.range_err;
        q_nxt.evt.status_valid = 1'b1;
        if (q_r.range_err) begin
          q_nxt.evt.status = STAT_ADDR;
        end else if (act.op == MBO_INC && inc_size_bad) begin
          q_nxt.evt.status = STAT_MISUSE; // RQ8
        end else begin
          q_nxt.evt.status = STAT_OK;
        end
        q_nxt.pend[q_r.cur] = 1'b0;
        q_nxt.st = ST_IDLE;
      end
    endcase
  end

  // The whole state is one register so reset clears every field at once.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Every byte comes out of reset with a known pattern, so a block operation
  // on memory that nobody has written is still repeatable; this costs a
  // reset on each storage flop. One entry per generate step.
  for (genvar i = 0; i < MEM_BYTES; i++) begin : g_mem
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_r[i] <= 8'(i) ^ MEM_INIT_XOR;
      end else if (mem_we && mem_wa == 10'(i)) begin
        mem_r[i] <= mem_wd;
      end
    end
  end

  // Outputs come straight from the state flops, so the host never sees a
  // combinational glitch on an event pulse.
  assign evt     = q_r.evt;
  assign busy_lo = q_r.pend[0];
  assign busy_hi = q_r.pend[1];
endmodule

// File: hdl/mbo_pkg.sv
// Package of constants and types for the memory block operation unit.
package mbo_pkg;
  localparam int          MEM_BYTES     = 1024;
  localparam logic [11:0] MEM_LAST      = 12'h3ff;
  localparam logic [11:0] INC_LAST_ADDR = 12'h3fc;
  localparam logic [1:0]  INC_SIZE_BAD  = 2'h3;
  localparam logic [7:0]  STAT_OK       = 8'h00;
  localparam logic [7:0]  STAT_ADDR     = 8'h01;
  localparam logic [7:0]  STAT_MISUSE   = 8'h02;
  localparam logic [7:0]  MEM_INIT_XOR  = 8'h5a;

  typedef enum logic [1:0] {MBO_COPYR, MBO_XOR, MBO_INC} mbo_op_t;

  typedef struct packed {
    logic        valid;
    mbo_op_t     op;
    logic        prio;
    logic [7:0]  count;
    logic [11:0] src;
    logic [11:0] dst;
  } mbo_cmd_t;

  typedef struct packed {
    logic       low_priority_done;
    logic       high_priority_done;
    logic       misuse_fault;
    logic       address_range_fault;
    logic       status_valid;
    logic [7:0] status;
  } mbo_evt_t;

  typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} mbo_state_t;
endpackage

// File: verification/mbo_host.sv
// Host model that hands commands to the unit.
module mbo_host
  import mbo_pkg::*;
(
  input  wire logic core_clk, // Clock.
  output mbo_cmd_t  cmd       // Command.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd = '0;
  task automatic issue(mbo_op_t o, logic p, logic [7:0] c,
                       logic [11:0] a, e);
    @(negedge core_clk);
    cmd <= '{1'b1, o, p, c, a, e};
    @(negedge core_clk);
    // Scrambled so that no stale operand can be trusted.
    cmd <= {1'b0, ~cmd[34:0]};
  endtask
endmodule

// File: verification/mbo_unit_properties.sv
// Port assertions for the block operation unit.
module mbo_unit_properties
  import mbo_pkg::*;
(
  input wire logic     core_clk, // Clock.
  input wire logic     rst_b,    // Reset.
  input wire mbo_cmd_t cmd,      // Command.
  input wire mbo_evt_t evt,      // Events.
  input wire logic     busy_lo,  // Low busy.
  input wire logic     busy_hi   // High busy.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic bsy = cmd.prio ? busy_hi : busy_lo;
  wire logic inc = cmd.valid && !busy_lo && !busy_hi && cmd.op == MBO_INC;
  chk_busy_refused: assert property (cmd.valid && bsy |->
    ##[1:2] evt.misuse_fault) else $error("no misuse");
  chk_low_start: assert property (cmd.valid && !cmd.prio && !busy_lo
    |=> busy_lo) else $error("low not busy");
  chk_low_done: assert property ($rose(busy_lo) |-> ##[1:600]
    evt.low_priority_done) else $error("low not done");
  chk_high_done: assert property ($rose(busy_hi) |-> ##[1:600]
    evt.high_priority_done) else $error("high not done");
  chk_status_done: assert property (evt.status_valid |->
    evt.low_priority_done || evt.high_priority_done) else $error("status");
  chk_inc_size: assert property (inc && cmd.count[1:0] == INC_SIZE_BAD
    |-> ##[1:8] evt.misuse_fault) else $error("size");
  chk_inc_range: assert property (inc && cmd.src > INC_LAST_ADDR &&
    cmd.count[1:0] != INC_SIZE_BAD |-> ##[1:8] evt.address_range_fault)
    else $error("range");
  chk_range_status: assert property (evt.address_range_fault |->
    ##[0:2] evt.status_valid && evt.status == STAT_ADDR) else $error("code");
endmodule
bind mbo_unit mbo_unit_properties chk (.core_clk, .rst_b, .cmd, .evt,
  .busy_lo, .busy_hi);

// File: verification/test_mbo_unit.sv
// Self-checking bench for the block operation unit.
module test_mbo_unit
  import mbo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 0, rst_b = 0, busy_lo, busy_hi;
  mbo_cmd_t   cmd;
  mbo_evt_t   evt;
  int         num_errors = 0, total_checks = 0, seed = 63;
  int         cyc = 0, mis = 0, rng = 0, em = 0, er = 0, n, r;
  logic [7:0] m [MEM_BYTES], es [2];
  mbo_host host (.core_clk, .cmd);
  mbo_unit dut (.core_clk, .rst_b, .cmd, .evt, .busy_lo, .busy_hi);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    mis += rst_b && evt.misuse_fault;
    rng += rst_b && evt.address_range_fault;
    if (++cyc == 20000) begin
      num_errors++;
      results;
    end
  end
  task automatic results;
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, want);
    total_checks++;
    if (got !== want) begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic go(mbo_op_t o, logic p, logic [7:0] c, logic [11:0] a, e);
    es[p] = STAT_OK;
    if (o == MBO_INC && c[1:0] == INC_SIZE_BAD) es[p] = STAT_MISUSE;
    else if (o == MBO_INC ? a > INC_LAST_ADDR :
             c != 0 && (a + c > MEM_BYTES || e + c > MEM_BYTES))
      es[p] = STAT_ADDR;
    else if (o == MBO_INC)
      for (n = 0; n < 1 << c[1:0] && ++m[a+n] == 0; n++) begin end
    else
      for (n = 0; n < c; n++)
        if (o == MBO_XOR) m[e+n] ^= m[a+n];
        else m[e+c-1-n] = m[a+n];
    em += es[p] == STAT_MISUSE;
    er += es[p] == STAT_ADDR;
    host.issue(o, p, c, a, e);
  endtask
  task automatic fin(logic [1:0] w);
    logic [1:0] d;
    for (n = 0; w && n < 900; n++) begin
      @(negedge core_clk);
      d = {evt.high_priority_done, evt.low_priority_done};
      for (int p = 0; p < 2; p++)
        if (w[p] && d[p] === 1'b1) begin
          chk(evt.status, es[p]);
          w[p] = 1'b0;
        end
    end
    chk({6'h00, w}, 8'h00);
    foreach (m[i]) chk(dut.mem_r[i], m[i]);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_b = 1;
    foreach (m[i]) m[i] = 8'(i) ^ MEM_INIT_XOR;
    for (r = 0; r < 4; r++) begin
      go(MBO_INC, r[0], 8'(r), 12'h3fc, 12'h000);
      fin(2'b1 << r[0]);
    end
    go(MBO_INC, 1, 8'h00, 12'h3fd, 12'h000);
    fin(2'h2);
    go(MBO_COPYR, 0, 8'h00, 12'h010, 12'h020);
    fin(2'h1);
    go(MBO_COPYR, 0, 8'h14, 12'h000, 12'h12c);
    host.issue(MBO_XOR, 0, 8'h01, 12'h000, 12'h000);
    em++;
    go(MBO_INC, 1, 8'h02, 12'h384, 12'h000);
    fin(2'h3);
    repeat (40) begin
      r = $random(seed);
      go(mbo_op_t'(r[1:0] % 3), r[2], 8'(1 + r[8:3]), 12'(r[19:9]),
         12'(r[29:20]));
      fin(2'b1 << r[2]);
    end
    chk(8'(mis), 8'(em));
    chk(8'(rng), 8'(er));
    results;
  end
endmodule
